// File: rtl/mpc_top.sv
// Functional notes
// [R1] Watchdog timeout is 1.6 ms times duration+1
// [R2] Restart command refreshes watchdog; expiry flags error
// [R3] Timeout duty select picks fixed or target duty
// [R4] Duty select MSB in watchdog reg, LSBs elsewhere
// [R5] Error mask bits suppress seven primary errors
// [R6] Second mask suppresses three further errors
// [R7] Diagnostic pin open drain, selectable polarity
// [R8] Restart after speed error once recovery elapses
// [R9] Latch bits choose auto recover or latch-off
// [R10] Latched-only bit limits diagnostic to latched errors
// [R11] Accel error after count+1 consecutive early crossings
// [R12] Decel error when crossing exceeds scaled period
// [R13] Checksum error powers down if selected, always reported
// [R14] Checksum at startup, download, periodic when running
// [R15] Open detect time selects coil current window
// [R16] Start duty ramps or follows; target optional fast
// [R17] Current ramp enables for free-run and stopped
// [R18] Sync rectification auto-off and soft-start forcing
// [R19] Duty from pins or ten-bit register value
// [R20] Slowdown mode stops drive until target speed
// [R21] Fast start duty drives at enable for 200 ms
// [R22] FET short debounce 1.6 to 6.4 us
// [R23] Overvoltage persistence 0.8 to 6.4 us
// [R24] Masked error neither stops drive nor signals
`timescale 1ns/100ps
`default_nettype none
`include "mpc_regs.svh"
module mpc_top #(
  parameter int WDOG_STEP = `MPC_WDOG_STEP_CYC,
  parameter int CSUM_PERIOD = `MPC_CSUM_PERIOD_CYC,
  parameter longint RCV_STEP = `MPC_RCV_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [9:0] pin_duty,
  input wire logic [9:0] target_low_duty,
  input wire logic [9:0] target_high_duty,
  input wire logic motor_running,
  input wire logic [9:0] err_raw,
  input wire logic csum_mismatch,
  input wire logic early_cross,
  input wire logic cross_event,
  input wire logic [15:0] cross_time,
  input wire logic [15:0] prev_period,
  input wire logic speed_ok,
  output logic diagnostic_output_out,
  output logic diagnostic_output_oe,
  output logic drive_stop,
  output logic wdog_override,
  output logic [9:0] wdog_duty,
  output logic [9:0] duty_in,
  output logic speed_error,
  output logic csum_start,
  output logic [7:0] soft_cfg,
  output logic [7:0] slow_cfg,
  output logic [7:0] speed_cfg,
  output logic [1:0] open_detect_time,
  output logic fet_short_ok,
  output logic overvolt_ok
);
  // ***********************************
  // Pin synchronisers
  // ***********************************
  logic [9:0] err_s1_reg, err_s2_reg;
  logic [2:0] ev_s1_reg, ev_s2_reg;
  logic cross_s3_reg, cross_rise;
  always_ff @(posedge clk_sys) begin
    err_s1_reg <= err_raw;
    err_s2_reg <= err_s1_reg;
    ev_s1_reg <= {csum_mismatch, early_cross, cross_event};
    ev_s2_reg <= ev_s1_reg;
    cross_s3_reg <= ev_s2_reg[0];
  end
  // Crossing pulses may last several cycles; count each one once
  assign cross_rise = ev_s2_reg[0] && !cross_s3_reg;
  // err bits: 0 supply low,1 locked,2 thw,3 thp,4 fet,5 ov,6 oc,
  // 7 supply ov,8 open,9 current limit
  // ***********************************
  // AHB-Lite slave
  // ***********************************
  mpc_pkg::mpc_byte_t regs_reg [0:6];
  mpc_pkg::mpc_byte_t regs_next [0:6];
  logic [7:0] duty_lo_reg, duty_lo_next, duty_hi_reg, duty_hi_next;
  logic wr_pend_reg, wr_pend_next;
  logic [11:0] wa_reg, wa_next;
  logic [31:0] hrdata_next;
  logic wdog_kick, csum_clr, latch_clr, odl_cmd;
  logic [7:0] csum_ref_reg;
  logic [7:0] fault_reg, fault_next;
  mpc_pkg::mpc_state_e st_reg, st_next;
  logic [11:0] ra;
  logic addr_ok;
  assign ra = haddr[13:2];
  assign addr_ok = hsel && hready && htrans[1];
  // Zero-wait slave; read data registered in the address phase
  always_comb begin
    hrdata_next = 32'h00000000;
    wr_pend_next = addr_ok && hwrite;
    wa_next = ra;
    if (addr_ok && !hwrite) begin
      case (ra)
        `MPC_IDX_CSUM: hrdata_next = {24'h000000, csum_ref_reg};
        `MPC_IDX_DUTYLO: hrdata_next = {24'h000000, duty_lo_reg};
        `MPC_IDX_DUTYHI: hrdata_next = {24'h000000, duty_hi_reg};
        `MPC_IDX_FAULT: hrdata_next = {24'h000000, fault_reg};
        `MPC_IDX_STAT: hrdata_next = {29'h0, st_reg};
        default: begin
          if (ra >= `MPC_IDX_WDOG && ra < `MPC_IDX_CSUM) begin
            hrdata_next = {24'h000000, regs_reg[3'(ra - `MPC_IDX_WDOG)]};
          end
        end
      endcase
    end
  end
  // Write-side next state, including command strobes
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      regs_next[i] = regs_reg[i];
    end
    duty_lo_next = duty_lo_reg;
    duty_hi_next = duty_hi_reg;
    wdog_kick = 1'b0;
    csum_clr = 1'b0;
    latch_clr = 1'b0;
    odl_cmd = 1'b0;
    if (wr_pend_reg) begin
      if (wa_reg >= `MPC_IDX_WDOG && wa_reg < `MPC_IDX_CSUM) begin
        regs_next[3'(wa_reg - `MPC_IDX_WDOG)] = hwdata[7:0];
      end
      if (wa_reg == `MPC_IDX_DUTYLO) duty_lo_next = hwdata[7:0];
      if (wa_reg == `MPC_IDX_DUTYHI) duty_hi_next = {6'h00, hwdata[1:0]};
      if (wa_reg == `MPC_IDX_RSTCMD) begin
        wdog_kick = hwdata[7:0] == `MPC_CMD_WDOG; // R2
        csum_clr = hwdata[7:0] == `MPC_CMD_CSUM;
        latch_clr = hwdata[7:0] == `MPC_CMD_LATCH;
      end
      if (wa_reg == `MPC_IDX_ODL) begin
        odl_cmd = hwdata[7:0] == `MPC_CMD_ODL; // R14
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < 7; i++) regs_reg[i] <= `MPC_RESET_VAL;
      duty_lo_reg <= `MPC_RESET_VAL;
      duty_hi_reg <= `MPC_RESET_VAL;
      wr_pend_reg <= 1'b0;
      wa_reg <= 12'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      for (int i = 0; i < 7; i++) regs_reg[i] <= regs_next[i];
      duty_lo_reg <= duty_lo_next;
      duty_hi_reg <= duty_hi_next;
      wr_pend_reg <= wr_pend_next;
      wa_reg <= wa_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // Field aliases
  logic [7:0] r_wd, r_em, r_rc, r_xm, r_sp, r_sl;
  assign r_wd = regs_reg[0];
  assign r_em = regs_reg[1];
  assign r_rc = regs_reg[2];
  assign r_xm = regs_reg[3];
  assign r_sp = regs_reg[5];
  assign r_sl = regs_reg[6];
  // ***********************************
  // Watchdog
  // ***********************************
  logic [31:0] wd_cnt_reg, wd_cnt_next;
  logic [6:0] wd_step_reg, wd_step_next;
  logic wd_err_reg, wd_err_next;
  logic [2:0] duty_sel;
  assign duty_sel = {r_wd[6], r_rc[5:4]}; // R4
  // Count runs only while enabled; kick restarts both stages
  always_comb begin
    wd_cnt_next = wd_cnt_reg;
    wd_step_next = wd_step_reg;
    wd_err_next = wd_err_reg;
    if (!r_wd[7] || wdog_kick) begin // R1 R2
      wd_cnt_next = 32'h0;
      wd_step_next = 7'h00;
      wd_err_next = 1'b0;
    end else if (!wd_err_reg) begin
      if (wd_cnt_reg == 32'(WDOG_STEP - 1)) begin
        wd_cnt_next = 32'h0;
        wd_step_next = wd_step_reg + 7'h01;
        if (wd_step_reg == {1'b0, r_wd[5:0]}) wd_err_next = 1'b1; // R1
      end else begin
        wd_cnt_next = wd_cnt_reg + 32'h1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wd_cnt_reg <= 32'h0;
      wd_step_reg <= 7'h00;
      wd_err_reg <= 1'b0;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
      wd_step_reg <= wd_step_next;
      wd_err_reg <= wd_err_next;
    end
  end
  // Fallback duty on timeout
  logic [9:0] wd_duty_c;
  always_comb begin
    case (duty_sel) // R3
      3'h1: wd_duty_c = 10'h100;
      3'h2: wd_duty_c = 10'h200;
      3'h3: wd_duty_c = 10'h300;
      3'h4: wd_duty_c = 10'h3ff;
      3'h5: wd_duty_c = target_low_duty;
      3'h6: wd_duty_c = target_high_duty;
      default: wd_duty_c = 10'h000;
    endcase
  end
  // ***********************************
  // Speed error detection
  // ***********************************
  logic [4:0] acc_cnt_reg, acc_cnt_next;
  logic spd_err_reg, spd_err_next;
  logic [19:0] dec_lim;
  always_comb begin
    case (r_sp[6:4]) // R12
      3'h0: dec_lim = {4'h0, prev_period} + {6'h00, prev_period[15:2]};
      3'h1: dec_lim = {4'h0, prev_period} + {5'h00, prev_period[15:1]};
      3'h2: dec_lim = 20'({prev_period, 1'b0}) - {6'h00, prev_period[15:2]};
      3'h3: dec_lim = {3'h0, prev_period, 1'b0};
      3'h4: dec_lim = {3'h0, prev_period, 1'b0} + {4'h0, prev_period};
      3'h5: dec_lim = {2'h0, prev_period, 2'h0};
      3'h6: dec_lim = {2'h0, prev_period, 2'h0} + {3'h0, prev_period, 1'b0};
      default: dec_lim = {1'b0, prev_period, 3'h0};
    endcase
  end
  // Recovery clears first, so a crossing in the same cycle still sets
  always_comb begin
    acc_cnt_next = acc_cnt_reg;
    spd_err_next = spd_err_reg;
    if (st_reg == mpc_pkg::MPC_WAIT && st_next == mpc_pkg::MPC_RUN) begin
      spd_err_next = 1'b0;
      acc_cnt_next = 5'h00;
    end
    if (cross_rise) begin
      if (r_xm[4] && ev_s2_reg[1]) begin // R11
        acc_cnt_next = acc_cnt_reg + 5'h01;
        if (acc_cnt_reg == {1'b0, r_sp[3:0]}) spd_err_next = 1'b1;
      end else begin
        acc_cnt_next = 5'h00;
      end
      if (r_sp[7] && {4'h0, cross_time} > dec_lim) spd_err_next = 1'b1; // R12
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_cnt_reg <= 5'h00;
      spd_err_reg <= 1'b0;
    end else begin
      acc_cnt_reg <= acc_cnt_next;
      spd_err_reg <= spd_err_next;
    end
  end
  // ***********************************
  // Recovery and latch-off
  // ***********************************
  logic [63:0] rcv_cnt_reg, rcv_cnt_next, rcv_lim;
  logic [9:0] err_act;
  logic latch_hit;
  // Mask bits run high to low against the error order
  assign err_act = err_s2_reg & ~{r_xm[5], r_xm[6], r_xm[7], r_em[1], r_em[2],
                                  r_em[3], r_em[4], r_em[5], r_em[6],
                                  r_em[7]}; // R5 R6 R24
  assign latch_hit = (err_act[1] && r_rc[3]) || (err_act[4] && r_rc[2]) ||
                     (err_act[6] && r_rc[1]); // R9
  always_comb begin
    case (r_rc[7:6]) // R8
      2'h0: rcv_lim = 64'h0;
      2'h1: rcv_lim = 64'(RCV_STEP);
      2'h2: rcv_lim = 64'(RCV_STEP * 2);
      default: rcv_lim = 64'(RCV_STEP * 4);
    endcase
  end
  always_comb begin
    st_next = st_reg;
    rcv_cnt_next = rcv_cnt_reg;
    case (st_reg)
      mpc_pkg::MPC_RUN: begin
        rcv_cnt_next = 64'h0;
        if (latch_hit) st_next = mpc_pkg::MPC_LATCHED; // R9
        else if (spd_err_reg) st_next = mpc_pkg::MPC_WAIT;
      end
      mpc_pkg::MPC_WAIT: begin
        rcv_cnt_next = rcv_cnt_reg + 64'h1;
        if (latch_hit) st_next = mpc_pkg::MPC_LATCHED;
        else if (rcv_cnt_reg >= rcv_lim) st_next = mpc_pkg::MPC_RUN; // R8
      end
      mpc_pkg::MPC_LATCHED: begin
        if (latch_clr) st_next = mpc_pkg::MPC_RUN;
      end
      default: st_next = mpc_pkg::MPC_RUN;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= mpc_pkg::MPC_RUN;
      rcv_cnt_reg <= 64'h0;
    end else begin
      st_reg <= st_next;
      rcv_cnt_reg <= rcv_cnt_next;
    end
  end
  // ***********************************
  // Checksum supervision
  // ***********************************
  logic [31:0] cs_cnt_reg, cs_cnt_next;
  logic cs_err_reg, cs_err_next, cs_start_next, boot_reg;
  logic csum_on;
  assign csum_on = 1'b1; // Check enable comes from OTP; assumed on
  always_comb begin
    cs_cnt_next = cs_cnt_reg;
    cs_start_next = boot_reg || odl_cmd; // R14
    if (r_xm[2] && motor_running) begin
      if (cs_cnt_reg == 32'(CSUM_PERIOD - 1)) begin
        cs_cnt_next = 32'h0;
        cs_start_next = 1'b1; // R14
      end else cs_cnt_next = cs_cnt_reg + 32'h1;
    end else cs_cnt_next = 32'h0;
    // Set wins over a clear in the same cycle
    cs_err_next = (cs_err_reg && !csum_clr) || (csum_on && ev_s2_reg[2]);
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cs_cnt_reg <= 32'h0;
      cs_err_reg <= 1'b0;
      boot_reg <= 1'b1;
      csum_start <= 1'b0;
      csum_ref_reg <= `MPC_RESET_VAL;
    end else begin
      cs_cnt_reg <= cs_cnt_next;
      cs_err_reg <= cs_err_next;
      boot_reg <= 1'b0;
      csum_start <= cs_start_next;
      csum_ref_reg <= csum_ref_reg;
    end
  end
  // ***********************************
  // Outputs
  // ***********************************
  logic diagnostic_output_act;
  assign diagnostic_output_act = (r_rc[0] ? latch_hit || st_reg == mpc_pkg::MPC_LATCHED
                    : |err_act || wd_err_reg || spd_err_reg) ||
                    cs_err_reg; // R10 R13
  always_comb begin
    fault_next = {1'b0, st_reg == mpc_pkg::MPC_LATCHED, cs_err_reg,
                  spd_err_reg, wd_err_reg, |err_act[9:7], |err_act[6:4],
                  |err_act[3:0]};
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      diagnostic_output_out <= 1'b0;
      diagnostic_output_oe <= 1'b0;
      drive_stop <= 1'b0;
      wdog_override <= 1'b0;
      wdog_duty <= 10'h000;
      duty_in <= 10'h000;
      speed_error <= 1'b0;
      soft_cfg <= 8'h00;
      slow_cfg <= 8'h00;
      speed_cfg <= 8'h00;
      open_detect_time <= 2'h0;
      fet_short_ok <= 1'b0;
      overvolt_ok <= 1'b0;
      fault_reg <= 8'h00;
    end else begin
      diagnostic_output_out <= 1'b0; // Open drain pulls low only
      diagnostic_output_oe <= r_em[0] ? !diagnostic_output_act : diagnostic_output_act; // R7
      drive_stop <= st_reg != mpc_pkg::MPC_RUN || |err_act ||
                    (cs_err_reg && r_xm[3]); // R13 R24
      wdog_override <= wd_err_reg; // R3
      wdog_duty <= wd_duty_c;
      duty_in <= regs_reg[4][0] ? {duty_hi_reg[1:0], duty_lo_reg}
                 : pin_duty; // R19
      speed_error <= spd_err_reg;
      soft_cfg <= regs_reg[4]; // R16 R17 R18
      slow_cfg <= r_sl; // R20 R21 R22 R23
      speed_cfg <= r_sp;
      open_detect_time <= r_xm[1:0]; // R15
      fet_short_ok <= !err_act[4];
      overvolt_ok <= !(err_act[5] || err_act[7]);
      fault_reg <= fault_next;
    end
  end
  // ***********************************
  // Assertions
  // ***********************************
  a_wdog_off: assert property (@(posedge clk_sys) disable iff (reset)
    !r_wd[7] |=> !wd_err_reg) else $error("watchdog err while off"); // R1
  a_kick_clear: assert property (@(posedge clk_sys) disable iff (reset)
    wdog_kick |=> !wd_err_reg) else $error("kick did not clear"); // R2
  a_duty_zero: assert property (@(posedge clk_sys) disable iff (reset)
    duty_sel == 3'h7 |=> wdog_duty == 10'h000) else $error("duty 7"); // R3
  a_mask_stop: assert property (@(posedge clk_sys) disable iff (reset)
    (err_s2_reg == 10'h0 && st_reg == mpc_pkg::MPC_RUN && !cs_err_reg)
    |=> !drive_stop) else $error("stop without cause"); // R24
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (reset)
    st_reg == mpc_pkg::MPC_LATCHED && !latch_clr |=>
    st_reg == mpc_pkg::MPC_LATCHED) else $error("latch lost"); // R9
  a_diagnostic_output_pol: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> diagnostic_output_oe == (r_em[0] ^ $past(diagnostic_output_act)) ||
    $changed(r_em[0])) else $error("diagnostic_output polarity"); // R7
  a_duty_src: assert property (@(posedge clk_sys) disable iff (reset)
    !regs_reg[4][0] && $stable(regs_reg[4][0]) |=>
    duty_in == $past(pin_duty)) else $error("duty source"); // R19
  a_csum_set: assert property (@(posedge clk_sys) disable iff (reset)
    ev_s2_reg[2] |=> cs_err_reg) else $error("csum err lost"); // R13
  c_wdog_trip: cover property (@(posedge clk_sys) wd_err_reg);
  c_latched: cover property (@(posedge clk_sys)
    st_reg == mpc_pkg::MPC_LATCHED);
  c_recover: cover property (@(posedge clk_sys)
    st_reg == mpc_pkg::MPC_WAIT ##1 st_reg == mpc_pkg::MPC_RUN);
endmodule : mpc_top
`default_nettype wire

// File: rtl/mpc_regs.svh
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH
// Register indices (printed offsets are not all word aligned)
`define MPC_IDX_WDOG 12'h107
`define MPC_IDX_EMASK 12'h108
`define MPC_IDX_RCV 12'h109
`define MPC_IDX_XMASK 12'h10a
`define MPC_IDX_SOFT 12'h10b
`define MPC_IDX_SPEED 12'h10c
`define MPC_IDX_SLOW 12'h10d
`define MPC_IDX_CSUM 12'h10e
`define MPC_IDX_RSTCMD 12'h300
`define MPC_IDX_DUTYLO 12'h301
`define MPC_IDX_DUTYHI 12'h302
`define MPC_IDX_ODL 12'h400
`define MPC_IDX_FAULT 12'h500
`define MPC_IDX_STAT 12'h501
`define MPC_RESET_VAL 8'h00
`define MPC_CMD_WDOG 8'h00
`define MPC_CMD_CSUM 8'h55
`define MPC_CMD_LATCH 8'hff
`define MPC_CMD_ODL 8'h00
// Timing, figures in ns
`define MPC_WDOG_STEP_NS 1600000
`define MPC_CLK_NS 4
`define MPC_WDOG_STEP_CYC (`MPC_WDOG_STEP_NS / `MPC_CLK_NS)
`define MPC_CSUM_PERIOD_NS 1000000
`define MPC_CSUM_PERIOD_CYC (`MPC_CSUM_PERIOD_NS / `MPC_CLK_NS)
`define MPC_RCV_STEP_NS 64'd5000000000
`define MPC_RCV_STEP_CYC (`MPC_RCV_STEP_NS / `MPC_CLK_NS)
`define MPC_FSP_STEP_NS 1600
`define MPC_FSP_STEP_CYC (`MPC_FSP_STEP_NS / `MPC_CLK_NS)
`define MPC_OVP_STEP_NS 800
`define MPC_OVP_STEP_CYC (`MPC_OVP_STEP_NS / `MPC_CLK_NS)
`endif

// File: rtl/mpc_pkg.sv
package mpc_pkg;
  typedef enum logic [2:0] {
    MPC_RUN = 3'b001,
    MPC_WAIT = 3'b010,
    MPC_LATCHED = 3'b100
  } mpc_state_e;
  typedef logic [7:0] mpc_byte_t;
endpackage : mpc_pkg

// File: tb/mpc_host.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host controller model: single AHB-Lite word transfers
// ****************************************
module mpc_host (
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // One transfer; each phase ends at the rising edge that sees ready,
  // and read data is taken at the data phase's closing edge
  task automatic xfer(input logic [11:0] idx, input logic wr,
                      input logic [7:0] wd, output logic [31:0] rd);
    haddr <= {18'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] x;
    xfer(idx, 1'b1, d, x);
  endtask : wr
  // Watchdog restart; must come before the programmed timeout
  task automatic kick();
    wr(12'h300, 8'h00);
  endtask : kick
endmodule : mpc_host
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0, reset = 1'b1, hreadyout, hresp, motor_running = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hwrite, csum_mismatch = 1'b0, early_cross = 1'b0, cross_event = 1'b0;
  logic [9:0] pin_duty = 10'h155, err_raw = 10'h0, wdog_duty, duty_in;
  logic [15:0] cross_time = 16'h0, prev_period = 16'h0;
  logic diagnostic_output_out, diagnostic_output_oe, drive_stop, wdog_override, speed_error, csum_start;
  logic fet_short_ok, overvolt_ok, hsel = 1'b1;
  logic [9:0] tgt_lo = 10'h111, tgt_hi = 10'h2a2;
  logic [7:0] soft_cfg, slow_cfg, speed_cfg;
  logic [1:0] open_detect_time;
  logic [9:0] exp_duty [8] = '{10'h0, 10'h100, 10'h200, 10'h300, 10'h3ff,
                             10'h111, 10'h2a2, 10'h0};
  int errors = 0, samples_checked = 0, starts = 0, se_cnt = 0, c0, mi;
  always #2 clk_sys = ~clk_sys;
  // Short counts keep the watchdog, checksum and recovery runs brief
  mpc_top #(.WDOG_STEP(4), .CSUM_PERIOD(8), .RCV_STEP(10)) dut (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_duty(pin_duty), .target_low_duty(tgt_lo),
    .target_high_duty(tgt_hi), .motor_running(motor_running),
    .err_raw(err_raw), .csum_mismatch(csum_mismatch),
    .early_cross(early_cross), .cross_event(cross_event),
    .cross_time(cross_time), .prev_period(prev_period), .speed_ok(1'b0),
    .diagnostic_output_out(diagnostic_output_out), .diagnostic_output_oe(diagnostic_output_oe), .drive_stop(drive_stop),
    .wdog_override(wdog_override), .wdog_duty(wdog_duty),
    .duty_in(duty_in), .speed_error(speed_error), .csum_start(csum_start),
    .soft_cfg(soft_cfg), .slow_cfg(slow_cfg), .speed_cfg(speed_cfg),
    .open_detect_time(open_detect_time), .fet_short_ok(fet_short_ok),
    .overvolt_ok(overvolt_ok));
  mpc_host host (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  // Pulse monitors: checksum starts and speed error cycles are counted
  always @(posedge clk_sys) begin
    if (csum_start === 1'b1) starts <= starts + 1;
    if (speed_error === 1'b1) se_cnt <= se_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdr(input logic [11:0] idx, input logic [7:0] exp);
    host.xfer(idx, 1'b0, 8'h0, rd);
    chk(rd, {24'h0, exp});
  endtask : rdr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic summarize();
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic pulse();
    cross_event <= 1'b1;
    cyc(4);
    cross_event <= 1'b0;
    cyc(4);
  endtask : pulse
  initial begin
    cyc(20000);
    errors++;
    summarize();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(3);
    reset <= 1'b0;
    cyc(1);
    // Reset values, write/read back, read-only and unmapped places
    for (int i = 0; i < 8; i++) rdr(12'h107 + i, 8'h00);
    for (int i = 0; i < 8; i++) host.wr(12'h107 + i, 8'h3c + i);
    for (int i = 0; i < 8; i++) rdr(12'h107 + i, i == 7 ? 8'h0 : 8'h3c + i);
    host.wr(12'h0ff, 8'h77);
    rdr(12'h0ff, 8'h00);
    chk(hresp, 1'b0);
    chk({soft_cfg, speed_cfg, slow_cfg}, 24'h404142);
    chk(open_detect_time, 2'h3);
    for (int i = 0; i < 7; i++) host.wr(12'h107 + i, 8'h00);
    // A transfer without select must leave the registers alone
    hsel <= 1'b0;
    host.wr(12'h10d, 8'h55);
    hsel <= 1'b1;
    rdr(12'h10d, 8'h00);
    // Duty source: pins, then the ten-bit register value
    chk(duty_in, 10'h155);
    host.wr(12'h301, 8'h34);
    host.wr(12'h302, 8'h02);
    host.wr(12'h10b, 8'h01);
    cyc(3);
    chk(duty_in, 10'h234);
    host.wr(12'h10b, 8'h00);
    // Watchdog of two steps (8 cycles) for every fallback duty code
    for (int s = 0; s < 8; s++) begin
      host.wr(12'h109, {2'h0, s[1:0], 4'h0});
      host.wr(12'h107, {1'b1, s[2], 6'h01});
      host.kick();
      cyc(5);
      chk(wdog_override, 1'b0);
      cyc(7);
      chk(wdog_override, 1'b1);
      chk(wdog_duty, exp_duty[s]);
    end
    host.wr(12'h107, 8'h00);
    host.wr(12'h109, 8'h00);
    cyc(3);
    chk(wdog_override, 1'b0);
    // Polarity: active high pulls the pin while no error stands
    host.wr(12'h108, 8'h01);
    cyc(3);
    chk(diagnostic_output_oe, 1'b1);
    chk(diagnostic_output_out, 1'b0);
    host.wr(12'h108, 8'h00);
    // Every error masked then unmasked; each held 600 cycles while masked
    for (int i = 0; i < 10; i++) begin
      mi = i < 7 ? 7 - i : 14 - i;
      host.wr(i < 7 ? 12'h108 : 12'h10a, 8'h01 << mi);
      err_raw <= 10'h1 << i;
      cyc(600);
      chk({diagnostic_output_oe, drive_stop}, 2'b00);
      host.wr(i < 7 ? 12'h108 : 12'h10a, 8'h00);
      cyc(5);
      chk(diagnostic_output_oe, 1'b1);
      chk(fet_short_ok, i != 4);
      chk(overvolt_ok, i != 5 && i != 7);
      err_raw <= 10'h0;
      cyc(30);
    end
    // Overcurrent latch-off with diagnostics for latched errors only
    host.wr(12'h109, 8'h03);
    err_raw <= 10'h040;
    cyc(10);
    err_raw <= 10'h0;
    cyc(10);
    rdr(12'h501, 8'h04);
    chk(diagnostic_output_oe, 1'b1);
    host.wr(12'h300, 8'hff);
    cyc(5);
    rdr(12'h501, 8'h01);
    err_raw <= 10'h004;
    cyc(10);
    chk(diagnostic_output_oe, 1'b0);
    err_raw <= 10'h0;
    host.wr(12'h109, 8'h00);
    // Checksum: download start, error report, power-down, periodic
    c0 = starts;
    host.wr(12'h400, 8'h00);
    cyc(5);
    chk(starts, c0 + 1);
    csum_mismatch <= 1'b1;
    cyc(10);
    chk({drive_stop, diagnostic_output_oe}, 2'b01);
    host.xfer(12'h500, 1'b0, 8'h0, rd);
    chk(rd[5], 1'b1);
    host.wr(12'h10a, 8'h08);
    cyc(5);
    chk(drive_stop, 1'b1);
    csum_mismatch <= 1'b0;
    cyc(3);
    host.wr(12'h300, 8'h55);
    host.wr(12'h10a, 8'h04);
    motor_running <= 1'b1;
    cyc(5);
    chk(drive_stop, 1'b0);
    chk(diagnostic_output_oe, 1'b0);
    c0 = starts;
    cyc(80);
    chk(starts - c0 >= 9 && starts - c0 <= 11, 1'b1);
    motor_running <= 1'b0;
    host.wr(12'h10a, 8'h00);
    // Acceleration error after three early crossings, then recovery
    host.wr(12'h109, 8'h40);
    host.wr(12'h10a, 8'h10);
    host.wr(12'h10c, 8'h02);
    early_cross <= 1'b1;
    c0 = se_cnt;
    pulse();
    pulse();
    cyc(4);
    chk(se_cnt, c0);
    pulse();
    cyc(4);
    chk(speed_error, 1'b1);
    rdr(12'h501, 8'h02);
    early_cross <= 1'b0;
    cyc(40);
    rdr(12'h501, 8'h01);
    chk(speed_error, 1'b0);
    // Deceleration: a crossing slower than 1.25 times the last period
    host.wr(12'h10a, 8'h00);
    host.wr(12'h10c, 8'h80);
    prev_period <= 16'h0064;
    cross_time <= 16'h007d;
    pulse();
    cyc(4);
    chk(speed_error, 1'b0);
    cross_time <= 16'h007e;
    pulse();
    cyc(4);
    chk(speed_error, 1'b1);
    summarize();
  end
endmodule : tb
`default_nettype wire
